//--- rtl/afcr_cmd_reg.sv
`timescale 1ns/1ps
module afcr_cmd_reg
    import afcr_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rstn_i,
    // Configuration access
    input  wire logic        cfg_wr_i,
    input  wire logic        cfg_rd_i,
    input  wire logic [7:0]  cfg_addr_i,
    input  wire logic [1:0]  cfg_be_i,
    input  wire logic [15:0] cfg_wdata_i,
    output logic [15:0]      cfg_rdata_o,
    output logic             cfg_ack_o,
    // Legacy interrupt source
    input  wire logic        intx_mode_i,
    input  wire logic        dma_intx_assert_i,
    input  wire logic        dma_intx_deassert_i,
    output logic             intx_assert_msg_o,
    output logic             intx_deassert_msg_o,
    // Link interrupt routing
    input  wire logic        link_intx_valid_i,
    input  wire logic [7:0]  link_intx_msg_i,
    output logic             route_intx_valid_o,
    output logic [7:0]       route_intx_msg_o,
    // Error events
    input  wire logic        port_uncor_fatal_i,
    input  wire logic        port_uncor_nonfatal_i,
    input  wire logic        rx_err_fatal_msg_i,
    input  wire logic        rx_err_nonfatal_msg_i,
    input  wire logic        parity_err_i,
    input  wire logic        master_parity_err_i,
    output logic             core_err_fatal_o,
    output logic             core_err_nonfatal_o,
    output logic             parity_signal_o,
    output logic             status_mdpe_set_o
);

    logic             par_resp_r;
    logic             err_en_r;
    logic             intx_dis_r;
    logic             intx_dis_prev_r;
    logic             cmd_hit;
    logic [15:0]      cmd_view;
    logic             dis_fall;
    logic             send_assert;
    logic             send_deassert;
    afcr_intx_state_t intx_state_r;
    afcr_intx_state_t intx_state_nxt;

    assign cmd_hit = cfg_addr_i == AFCR_CMD_OFFSET;

    // Stored fields; all other bits are constant zero
    always_comb
    begin
        cmd_view                                 = AFCR_CMD_RESET;
        cmd_view[AFCR_RSVD_MSB:AFCR_RSVD_LSB]    = '0;
        cmd_view[AFCR_BIT_FAST_B2B]              = 1'b0;
        cmd_view[AFCR_BIT_WAIT_CTL]              = 1'b0;
        cmd_view[AFCR_BIT_INTX_DIS]              = intx_dis_r;
        cmd_view[AFCR_BIT_ERR_EN]                = err_en_r;
        cmd_view[AFCR_BIT_PAR_RESP]              = par_resp_r;
    end

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            intx_dis_r <= AFCR_INTX_DIS_RST;
            err_en_r   <= AFCR_ERR_EN_RST;
            par_resp_r <= AFCR_PAR_RESP_RST;
        end
        else if (cfg_wr_i && cmd_hit)
        begin
            if (cfg_be_i[1])
            begin
                intx_dis_r <= cfg_wdata_i[AFCR_BIT_INTX_DIS];
                err_en_r   <= cfg_wdata_i[AFCR_BIT_ERR_EN];
            end
            if (cfg_be_i[0])
            begin
                par_resp_r <= cfg_wdata_i[AFCR_BIT_PAR_RESP];
            end
        end
    end

    // Read data and access acknowledge, one cycle after the request
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cfg_rdata_o <= AFCR_CMD_RESET;
            cfg_ack_o   <= 1'b0;
        end
        else
        begin
            cfg_ack_o <= cfg_rd_i | cfg_wr_i;
            if (cfg_rd_i)
            begin
                cfg_rdata_o <= cmd_hit ? cmd_view : 16'h0000;
            end
        end
    end

    // Legacy interrupt message generation
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            intx_dis_prev_r <= AFCR_INTX_DIS_RST;
        end
        else
        begin
            intx_dis_prev_r <= intx_dis_r;
        end
    end

    assign dis_fall      = intx_dis_prev_r & ~intx_dis_r;
    assign send_assert   = (intx_state_r == AFCR_INTX_IDLE) & dma_intx_assert_i
                           & intx_mode_i & ~intx_dis_r;
    assign send_deassert = (intx_state_r == AFCR_INTX_SENT) & (dma_intx_deassert_i | dis_fall);

    always_comb
    begin
        intx_state_nxt = intx_state_r;
        unique case (intx_state_r)
            AFCR_INTX_IDLE:
            begin
                if (send_assert)
                begin
                    intx_state_nxt = AFCR_INTX_SENT;
                end
            end
            AFCR_INTX_SENT:
            begin
                if (send_deassert)
                begin
                    intx_state_nxt = AFCR_INTX_IDLE;
                end
            end
            default:
            begin
                intx_state_nxt = AFCR_INTX_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            intx_state_r        <= AFCR_INTX_IDLE;
            intx_assert_msg_o   <= 1'b0;
            intx_deassert_msg_o <= 1'b0;
        end
        else
        begin
            intx_state_r        <= intx_state_nxt;
            intx_assert_msg_o   <= send_assert;
            intx_deassert_msg_o <= send_deassert;
        end
    end

    // Link interrupt messages pass without regard to the disable bit
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            route_intx_valid_o <= 1'b0;
            route_intx_msg_o   <= 8'h00;
        end
        else
        begin
            route_intx_valid_o <= link_intx_valid_i;
            if (link_intx_valid_i)
            begin
                route_intx_msg_o <= link_intx_msg_i;
            end
        end
    end

    afcr_err_gate u_err_gate (
        .core_clk_i            (core_clk_i),
        .rstn_i                (rstn_i),
        .err_en_i              (err_en_r),
        .par_resp_i            (par_resp_r),
        .port_uncor_fatal_i    (port_uncor_fatal_i),
        .port_uncor_nonfatal_i (port_uncor_nonfatal_i),
        .rx_err_fatal_msg_i    (rx_err_fatal_msg_i),
        .rx_err_nonfatal_msg_i (rx_err_nonfatal_msg_i),
        .parity_err_i          (parity_err_i),
        .master_parity_err_i   (master_parity_err_i),
        .core_err_fatal_o      (core_err_fatal_o),
        .core_err_nonfatal_o   (core_err_nonfatal_o),
        .parity_signal_o       (parity_signal_o),
        .status_mdpe_set_o     (status_mdpe_set_o)
    );

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);

    property p_intx_blocked;
        (dma_intx_assert_i && (intx_dis_r || !intx_mode_i)) |=> !intx_assert_msg_o;
    endproperty
    a_intx_blocked: assert property (p_intx_blocked) else $error("assert sent while disabled");

    property p_deassert_on_clear;
        (dis_fall && intx_state_r == AFCR_INTX_SENT) |=> intx_deassert_msg_o ##1 !intx_deassert_msg_o;
    endproperty
    a_deassert_on_clear: assert property (p_deassert_on_clear) else $error("no deassert on clear");

    property p_link_route;
        link_intx_valid_i |=> route_intx_valid_o && route_intx_msg_o == $past(link_intx_msg_i);
    endproperty
    a_link_route: assert property (p_link_route) else $error("link interrupt not routed");

    property p_fastb2b_zero;
        cfg_ack_o |-> !cfg_rdata_o[AFCR_BIT_FAST_B2B];
    endproperty
    a_fastb2b_zero: assert property (p_fastb2b_zero) else $error("fast back-to-back reads one");

    property p_waitctl_zero;
        cfg_ack_o |-> !cfg_rdata_o[AFCR_BIT_WAIT_CTL];
    endproperty
    a_waitctl_zero: assert property (p_waitctl_zero) else $error("wait control reads one");

    property p_rsvd_zero;
        (cfg_rd_i && cmd_hit) |=> cfg_rdata_o[AFCR_RSVD_MSB:AFCR_RSVD_LSB] == 5'h00;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");

    property p_outstanding;
        (intx_state_r == AFCR_INTX_SENT) |=> (intx_state_r == AFCR_INTX_SENT) || intx_deassert_msg_o;
    endproperty
    a_outstanding: assert property (p_outstanding) else $error("outstanding flag lost");

    property p_no_double_assert;
        intx_assert_msg_o |=> !intx_assert_msg_o;
    endproperty
    a_no_double_assert: assert property (p_no_double_assert) else $error("second assert unpaired");

    c_assert_msg:   cover property (intx_assert_msg_o);
    c_clear_deasrt: cover property (dis_fall && intx_state_r == AFCR_INTX_SENT);
    c_link_route:   cover property (link_intx_valid_i && intx_dis_r);

endmodule

//--- common/afcr_pkg.sv
package afcr_pkg;

    // Configuration space placement of the command register
    localparam logic [7:0]  AFCR_CMD_OFFSET    = 8'h04;
    localparam logic [15:0] AFCR_CMD_RESET     = 16'h0000;

    // Field positions
    localparam int          AFCR_BIT_PAR_RESP  = 6;
    localparam int          AFCR_BIT_WAIT_CTL  = 7;
    localparam int          AFCR_BIT_ERR_EN    = 8;
    localparam int          AFCR_BIT_FAST_B2B  = 9;
    localparam int          AFCR_BIT_INTX_DIS  = 10;
    localparam int          AFCR_RSVD_LSB      = 11;
    localparam int          AFCR_RSVD_MSB      = 15;

    // Reset values of the stored fields
    localparam logic        AFCR_PAR_RESP_RST  = 1'b0;
    localparam logic        AFCR_ERR_EN_RST    = 1'b0;
    localparam logic        AFCR_INTX_DIS_RST  = 1'b0;

    // Legacy interrupt message states
    typedef enum logic [1:0] {
        AFCR_INTX_IDLE = 2'b01,
        AFCR_INTX_SENT = 2'b10
    } afcr_intx_state_t;

endpackage

//--- rtl/afcr_err_gate.sv
`timescale 1ns/1ps
module afcr_err_gate
    import afcr_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic rstn_i,
    // Command fields
    input  wire logic err_en_i,
    input  wire logic par_resp_i,
    // Port error events
    input  wire logic port_uncor_fatal_i,
    input  wire logic port_uncor_nonfatal_i,
    input  wire logic rx_err_fatal_msg_i,
    input  wire logic rx_err_nonfatal_msg_i,
    input  wire logic parity_err_i,
    input  wire logic master_parity_err_i,
    // To core error logic and status
    output logic      core_err_fatal_o,
    output logic      core_err_nonfatal_o,
    output logic      parity_signal_o,
    output logic      status_mdpe_set_o
);

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            core_err_fatal_o    <= 1'b0;
            core_err_nonfatal_o <= 1'b0;
        end
        else
        begin
            core_err_fatal_o    <= err_en_i & (port_uncor_fatal_i | rx_err_fatal_msg_i);
            core_err_nonfatal_o <= err_en_i & (port_uncor_nonfatal_i | rx_err_nonfatal_msg_i);
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            parity_signal_o   <= 1'b0;
            status_mdpe_set_o <= 1'b0;
        end
        else
        begin
            parity_signal_o   <= parity_err_i;
            status_mdpe_set_o <= par_resp_i & master_parity_err_i;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);

    property p_err_port_gate;
        (port_uncor_fatal_i || port_uncor_nonfatal_i) |=>
            (core_err_fatal_o || core_err_nonfatal_o) == $past(err_en_i);
    endproperty
    a_err_port_gate: assert property (p_err_port_gate) else $error("port error gating wrong");

    property p_err_msg_gate;
        (rx_err_fatal_msg_i && !port_uncor_fatal_i) |=> core_err_fatal_o == $past(err_en_i);
    endproperty
    a_err_msg_gate: assert property (p_err_msg_gate) else $error("error message forwarding wrong");

    property p_parity_always;
        parity_err_i |=> parity_signal_o;
    endproperty
    a_parity_always: assert property (p_parity_always) else $error("parity signal lost");

    property p_mdpe_qual;
        status_mdpe_set_o |-> $past(par_resp_i) && $past(master_parity_err_i);
    endproperty
    a_mdpe_qual: assert property (p_mdpe_qual) else $error("status parity set unqualified");

    c_fatal_fwd: cover property (rx_err_fatal_msg_i && err_en_i ##1 core_err_fatal_o);

endmodule

//--- bench/afcr_host_model.sv
`timescale 1ns/1ps
module afcr_host_model
(
    // Clock
    input  wire logic        core_clk_i,
    // Configuration master side
    output logic             cfg_wr_o,
    output logic             cfg_rd_o,
    output logic [7:0]       cfg_addr_o,
    output logic [1:0]       cfg_be_o,
    output logic [15:0]      cfg_wdata_o,
    input  wire logic [15:0] cfg_rdata_i,
    input  wire logic        cfg_ack_i
);
    initial
    begin
        cfg_wr_o    = 1'b0;
        cfg_rd_o    = 1'b0;
        cfg_addr_o  = 8'h00;
        cfg_be_o    = 2'h0;
        cfg_wdata_o = 16'h0000;
    end

    // One access, strobe for one cycle, then bounded wait for ack
    task automatic access(input logic wr, input logic [7:0] a, input logic [1:0] be,
                          input logic [15:0] d, output logic [15:0] rd);
        int n;
        n = 0;
        @(posedge core_clk_i);
        cfg_wr_o    <= wr;
        cfg_rd_o    <= ~wr;
        cfg_addr_o  <= a;
        cfg_be_o    <= be;
        cfg_wdata_o <= d;
        @(posedge core_clk_i);
        cfg_wr_o    <= 1'b0;
        cfg_rd_o    <= 1'b0;
        // Released bus shows garbage, not the last value
        cfg_addr_o  <= ~a;
        cfg_wdata_o <= ~d;
        do
        begin
            @(posedge core_clk_i);
            n++;
        end
        while (cfg_ack_i !== 1'b1 && n < 4);
        rd = (n < 4) ? cfg_rdata_i : 16'hxxxx;
    endtask
endmodule

//--- bench/tb.sv
`timescale 1ns/1ps
module tb;
    import afcr_pkg::*;
    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        intx_mode = 1'b0;
    logic        cfg_wr, cfg_rd, cfg_ack, asrt_msg, deas_msg, route_valid;
    logic        err_fatal, err_nonfatal, par_sig, mdpe_set;
    logic [7:0]  cfg_addr, route_msg;
    logic [7:0]  link_msg = 8'h00;
    logic [1:0]  cfg_be;
    logic [15:0] cfg_wdata, cfg_rdata, rdv, cur, d;
    logic [8:0]  stim = 9'h000;
    logic [3:0]  c;
    int          fails = 0, checked = 0, cycles = 0, seed = 96, n_asrt = 0, n_deas = 0, k, e;

    always #2.5 core_clk = ~core_clk;

    always @(posedge core_clk)
    begin
        cycles++;
        if (asrt_msg === 1'b1) n_asrt++;
        if (deas_msg === 1'b1) n_deas++;
        if (cycles == 20000)
        begin
            fails++;
            results();
        end
    end

    afcr_host_model afcr_host_model_inst (.core_clk_i(core_clk), .cfg_wr_o(cfg_wr), .cfg_rd_o(cfg_rd),
        .cfg_addr_o(cfg_addr), .cfg_be_o(cfg_be), .cfg_wdata_o(cfg_wdata), .cfg_rdata_i(cfg_rdata),
        .cfg_ack_i(cfg_ack));

    afcr_cmd_reg afcr_cmd_reg_inst (.core_clk_i(core_clk), .rstn_i(rstn), .cfg_wr_i(cfg_wr),
        .cfg_rd_i(cfg_rd), .cfg_addr_i(cfg_addr), .cfg_be_i(cfg_be), .cfg_wdata_i(cfg_wdata),
        .cfg_rdata_o(cfg_rdata), .cfg_ack_o(cfg_ack), .intx_mode_i(intx_mode),
        .dma_intx_assert_i(stim[6]), .dma_intx_deassert_i(stim[7]), .intx_assert_msg_o(asrt_msg),
        .intx_deassert_msg_o(deas_msg), .link_intx_valid_i(stim[8]), .link_intx_msg_i(link_msg),
        .route_intx_valid_o(route_valid), .route_intx_msg_o(route_msg), .port_uncor_fatal_i(stim[0]),
        .port_uncor_nonfatal_i(stim[1]), .rx_err_fatal_msg_i(stim[2]), .rx_err_nonfatal_msg_i(stim[3]),
        .parity_err_i(stim[4]), .master_parity_err_i(stim[5]), .core_err_fatal_o(err_fatal),
        .core_err_nonfatal_o(err_nonfatal), .parity_signal_o(par_sig), .status_mdpe_set_o(mdpe_set));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results;
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Event pulse for one cycle; outputs settle just after the taking edge
    task automatic pulse(input logic [8:0] v, input logic [7:0] m);
        @(posedge core_clk);
        stim     <= v;
        link_msg <= m;
        @(posedge core_clk);
        stim     <= 9'h000;
        #1;
    endtask

    task automatic wreg(input logic [15:0] wd, input logic [1:0] be);
        afcr_host_model_inst.access(1'b1, AFCR_CMD_OFFSET, be, wd, rdv);
    endtask

    task automatic rreg(input logic [7:0] a, input logic [15:0] exp);
        afcr_host_model_inst.access(1'b0, a, 2'b11, 16'h0000, rdv);
        chk(rdv, exp);
    endtask

    // Only the three stored fields survive a write
    function automatic logic [15:0] exp_cmd(input logic [15:0] old, input logic [15:0] wd, input logic [1:0] be);
        logic [15:0] r;
        r = old;
        if (be[1])
        begin
            r[AFCR_BIT_INTX_DIS] = wd[AFCR_BIT_INTX_DIS];
            r[AFCR_BIT_ERR_EN]   = wd[AFCR_BIT_ERR_EN];
        end
        if (be[0])
            r[AFCR_BIT_PAR_RESP] = wd[AFCR_BIT_PAR_RESP];
        return r & 16'h0540;
    endfunction

    initial
    begin
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        rreg(AFCR_CMD_OFFSET, AFCR_CMD_RESET);
        cur = AFCR_CMD_RESET;
        for (k = 0; k < 12; k++)
        begin
            d = (k == 0) ? 16'hffff : 16'($random(seed));
            wreg(d, 2'(k));
            cur = exp_cmd(cur, d, 2'(k));
            rreg(AFCR_CMD_OFFSET, cur);
        end
        afcr_host_model_inst.access(1'b1, 8'h08, 2'b11, 16'hffff, rdv);
        rreg(8'h08, 16'h0000);
        rreg(AFCR_CMD_OFFSET, cur);
        for (c = 0; c < 4; c++)
        begin
            wreg({7'h00, c[0], 1'b0, c[1], 6'h00}, 2'b11);
            for (e = 0; e < 6; e++)
            begin
                pulse(9'(1 << e), 8'h00);
                chk({12'h000, err_fatal, err_nonfatal, par_sig, mdpe_set}, {12'h000, c[0] && (e == 0 || e == 2),
                    c[0] && (e == 1 || e == 3), e == 4, c[1] && e == 5});
            end
        end
        wreg(16'h0400, 2'b11);
        for (k = 0; k < 4; k++)
        begin
            d[7:0] = 8'($random(seed));
            pulse(9'h100, d[7:0]);
            chk({7'h00, route_valid, route_msg}, {8'h01, d[7:0]});
        end
        @(posedge core_clk) intx_mode <= 1'b1;
        pulse(9'h040, 8'h00);
        chk(16'(n_asrt), 16'h0000);
        wreg(16'h0000, 2'b11);
        @(posedge core_clk) intx_mode <= 1'b0;
        pulse(9'h040, 8'h00);
        chk(16'(n_asrt), 16'h0000);
        @(posedge core_clk) intx_mode <= 1'b1;
        pulse(9'h040, 8'h00);
        chk({15'h0000, asrt_msg}, 16'h0001);
        for (k = 0; k < 2; k++)
        begin
            wreg(16'h0400, 2'b11);
            wreg(16'h0000, 2'b11);
            repeat (3) @(posedge core_clk);
            #1;
            chk(16'(n_deas), 16'h0001);
        end
        pulse(9'h040, 8'h00);
        pulse(9'h080, 8'h00);
        @(posedge core_clk);
        #1;
        chk(16'({n_asrt[7:0], n_deas[7:0]}), 16'h0202);
        results();
    end
endmodule
